//--- shared/tbm_pkg.sv
//------------------------------------------------------------------------------
// Purpose : Constants for the receive backplane 16.384 Mbit/s multiplexer
// Assumes : One backplane frame of 2048 bit times per 125 us
// Notes   : Positions count bit times from the first framing bit of a frame
//------------------------------------------------------------------------------
package tbm_pkg;

    // -------------------------------------------------------------------------
    // Mode selection
    // -------------------------------------------------------------------------
    localparam logic [1:0] MODE_BITMUX = 2'h1; // Bit interleaved 16.384 MHz
    localparam logic [1:0] MODE_HMVIP  = 2'h2; // Byte interleaved 16.384 MHz

    // -------------------------------------------------------------------------
    // Frame geometry
    // -------------------------------------------------------------------------
    localparam int         POS_W          = 11;    // 2048 bit times per frame
    localparam int         GROUPS         = 2;     // Channels 0-3 and 4-7
    localparam int         CH_PER_GROUP   = 4;
    localparam int         SLOTS          = 24;    // DS1 timeslots
    localparam int         MEM_DEPTH      = 96;    // SLOTS * CH_PER_GROUP
    localparam int         MEM_AW         = 7;
    localparam int         MEM_W          = 12;    // Payload byte + ABCD
    localparam logic [1:0] HDR_QUARTER    = 2'h0;  // First 64 bits of a block
    localparam logic [2:0] FBIT_BLOCK     = 3'h0;  // Block holding framing bits
    localparam logic [4:0] SLOTS_PER_BLK  = 5'h3;  // Timeslots per 256-bit block
    localparam logic [2:0] SIG_FIRST_BIT  = 3'h4;  // Payload bit 5 (one based)
    localparam logic [POS_W-1:0] POS_FRAME_START = 11'h000;
    localparam logic [POS_W-1:0] POS_HMVIP_LEAD  = 11'h7fe; // Sync leads by two

endpackage

//--- design/tbm_frame_store.sv
//------------------------------------------------------------------------------
// Purpose : Per-group store of payload bytes and signaling nibbles
// Assumes : Single clock, one write and one read port
// Notes   : Read data come out of a register, one cycle after the address
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module tbm_frame_store
#(
    parameter int DEPTH = 96,
    parameter int WIDTH = 12,
    parameter int AW    = 7
)
(
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage has no reset; the framer fills it before a frame is read
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule // tbm_frame_store

//--- design/tbm_rx_mux.sv
//------------------------------------------------------------------------------
// Purpose : Receive backplane multiplexer, four DS1 streams per 16.384 Mbit/s
//           serial output, bit multiplexed or byte interleaved
// Assumes : clk well above twice the backplane bit clock; framer side writes
//           on clk
// Notes   : Each group of four channels runs on its own bit clock and sync
//------------------------------------------------------------------------------
`timescale 1ns/10ps
module tbm_rx_mux
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       mux_enable,
    input  wire logic [1:0] interface_mode,
    input  wire logic       rx_backplane_bit_clock_low,
    input  wire logic       rx_backplane_bit_clock_high,
    input  wire logic       rx_backplane_frame_sync_low,
    input  wire logic       rx_backplane_frame_sync_high,
    input  wire logic [7:0] framing_bit,
    input  wire logic       wr_en,
    input  wire logic [2:0] wr_channel,
    input  wire logic [4:0] wr_slot,
    input  wire logic [7:0] wr_payload,
    input  wire logic [3:0] wr_signaling,
    output logic            group_low_serial_out,
    output logic            group_high_serial_out
);

    import tbm_pkg::*;

    // -------------------------------------------------------------------------
    // Mode decode
    // -------------------------------------------------------------------------
    logic mode_hmvip;
    logic mode_active;
    logic [GROUPS-1:0] bclk_pin;
    logic [GROUPS-1:0] sync_pin;
    logic [GROUPS-1:0] ser_out;

    assign mode_hmvip  = (interface_mode == MODE_HMVIP);
    assign mode_active = mux_enable && (mode_hmvip ||
                         (interface_mode == MODE_BITMUX));
    assign bclk_pin = {rx_backplane_bit_clock_high, rx_backplane_bit_clock_low};
    assign sync_pin = {rx_backplane_frame_sync_high, rx_backplane_frame_sync_low};
    assign group_low_serial_out  = ser_out[0];
    assign group_high_serial_out = ser_out[1];

    // -------------------------------------------------------------------------
    // One independent multiplexer per group of four channels
    // -------------------------------------------------------------------------
    for (genvar g = 0; g < GROUPS; g++)
    begin : g_group
        logic              bclk_meta;
        logic              bclk_sync;
        logic              bclk_prev;
        logic              fsync_meta;
        logic              fsync_sync;
        logic              fsync_prev;
        logic              next_bclk_meta;
        logic              next_bclk_sync;
        logic              next_bclk_prev;
        logic              next_fsync_meta;
        logic              next_fsync_sync;
        logic              next_fsync_prev;
        logic [POS_W-1:0]  pos;
        logic [POS_W-1:0]  next_pos;
        logic              ser;
        logic              next_ser;
        logic              bclk_rise;
        logic [POS_W-1:0]  look_pos;
        logic [MEM_AW-1:0] rd_addr;
        logic [MEM_W-1:0]  rd_data;
        logic              grp_wr;
        logic [3:0]        fbits;

        assign grp_wr = wr_en && (wr_channel[2] == 1'(g));
        assign fbits  = framing_bit[g*CH_PER_GROUP +: CH_PER_GROUP];

        // Per-group store: address is timeslot * 4 + channel within group
        tbm_frame_store
        #(
            .DEPTH (MEM_DEPTH),
            .WIDTH (MEM_W),
            .AW    (MEM_AW)
        )
        u_store
        (
            .clk     (clk),
            .wr_en   (grp_wr),
            .wr_addr (MEM_AW'({wr_slot, wr_channel[1:0]})),
            .wr_data ({wr_payload, wr_signaling}),
            .rd_addr (rd_addr),
            .rd_data (rd_data)
        );

        // ---------------------------------------------------------------------
        // Position decode for the look-ahead read of the store
        // ---------------------------------------------------------------------
        // The store is read one position ahead so its registered data are
        // ready when the next bit clock rise arrives; edges are >= 2 clk apart
        always_comb
        begin
            logic [4:0] slot;
            logic [1:0] chan;
            slot     = 5'h0;
            chan     = 2'h0;
            look_pos = pos + 11'h001;
            slot     = 5'(look_pos[10:8] * SLOTS_PER_BLK) +
                       5'(look_pos[7:6] - 2'h1);
            chan     = mode_hmvip ? look_pos[5:4] : look_pos[2:1];
            rd_addr  = MEM_AW'({slot, chan});
        end

        // ---------------------------------------------------------------------
        // Synchronisers, frame alignment and bit selection
        // ---------------------------------------------------------------------
        always_comb
        begin
            logic [2:0] pbit;
            logic [1:0] chan;
            pbit            = 3'h0;
            chan            = 2'h0;
            next_bclk_meta  = bclk_pin[g];
            next_bclk_sync  = bclk_meta;
            next_bclk_prev  = bclk_sync;
            next_fsync_meta = sync_pin[g];
            next_fsync_sync = fsync_meta;
            next_fsync_prev = fsync_prev;
            bclk_rise       = bclk_sync && !bclk_prev;
            next_pos        = pos;
            next_ser        = ser;
            if (bclk_rise)
            begin
                // Sync level is taken only at the bit clock rise
                next_fsync_prev = fsync_sync;
                next_pos        = pos + 11'h001;
                if (!mode_hmvip && fsync_sync)
                begin
                    next_pos = POS_FRAME_START;
                end
                else if (mode_hmvip && fsync_sync && !fsync_prev)
                begin
                    next_pos = POS_HMVIP_LEAD;
                end
                // Bit within the timeslot depends on the interleave
                pbit = mode_hmvip ? next_pos[3:1] : next_pos[5:3];
                chan = next_pos[2:1];
                if (!mode_active)
                begin
                    next_ser = 1'b0;
                end
                else if (next_pos[7:6] == HDR_QUARTER)
                begin
                    // Framing octet in block 0, all other header bits zero
                    if (next_pos[10:8] == FBIT_BLOCK && next_pos[5:3] == 3'h0)
                    begin
                        next_ser = fbits[chan];
                    end
                    else
                    begin
                        next_ser = 1'b0;
                    end
                end
                else if (next_pos[0] && pbit >= SIG_FIRST_BIT)
                begin
                    // Second copy of bits five to eight carries A, B, C, D
                    next_ser = rd_data[3'h7 - pbit];
                end
                else
                begin
                    // Both copies of bits one to four, first copy of the rest
                    next_ser = rd_data[4'h4 + 4'(3'h7 - pbit)];
                end
            end
        end
        // Header quarter of each 256-bit block is 64 filler bits (framing octet first in block 0)
        // before the payload of three timeslots
        // Every block: 8 header octets, then 24 payload octets
        // Filler is zero so the stream is repeatable
        // Channel split of both modes is done in the look-ahead decode, bit select at the rise

        always_ff @(posedge clk)
        begin
            if (!rst_n)
            begin
                bclk_meta  <= 1'b0;
                bclk_sync  <= 1'b0;
                bclk_prev  <= 1'b0;
                fsync_meta <= 1'b0;
                fsync_sync <= 1'b0;
                fsync_prev <= 1'b0;
                pos        <= POS_FRAME_START;
                ser        <= 1'b0;
            end
            else
            begin
                bclk_meta  <= next_bclk_meta;
                bclk_sync  <= next_bclk_sync;
                bclk_prev  <= next_bclk_prev;
                fsync_meta <= next_fsync_meta;
                fsync_sync <= next_fsync_sync;
                fsync_prev <= next_fsync_prev;
                pos        <= next_pos;
                ser        <= next_ser;
            end
        end

        assign ser_out[g] = ser;
    end

endmodule // tbm_rx_mux

//--- dv/tbm_term_model.sv
// Purpose : Terminal equipment model for one backplane group
// Assumes : Free running 200 ns bit clock, 2048 bits per frame
// Notes   : Keeps the latest captured bit of each position in cap and counts frame wraps
`timescale 1ns/10ps
module tbm_term_model
#(
    parameter real         PHASE = 7.0,
    parameter logic [10:0] START = 11'h7f8
)
(
    input  wire logic hmvip,
    input  wire logic serial_in,
    output logic      bit_clock,
    output logic      frame_sync
);
    logic [10:0]   pos;
    int            frames;
    logic [2047:0] cap;

    // ----------
    // Clock never stops, even between frames
    // ----------
    initial
    begin
        bit_clock = 1'b0;
        frame_sync = 1'b0;
        frames = 0;
        pos = START;
        cap = '0;
        #PHASE;
        forever #100 bit_clock = ~bit_clock;
    end

    // Latch on the fall; sync is set here for the rise that follows
    always @(negedge bit_clock)
    begin
        cap[pos] <= serial_in;
        frames <= (pos == 11'h7ff) ? frames + 1 : frames;
        pos <= pos + 11'h1;
        frame_sync <= hmvip ? (pos >= 11'h7fd || pos == 11'h000)
                            : (pos == 11'h7ff);
    end
endmodule // tbm_term_model

//--- dv/tbm_rx_mux_chk.sv
// Purpose : Port level checks of the backplane multiplexer
// Assumes : Bit clock period is eight clk cycles with fixed phase
// Notes   : Sample points leave one clk of slack around each update
`timescale 1ns/10ps
module tbm_rx_mux_chk
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       mux_enable,
    input wire logic [1:0] interface_mode,
    input wire logic       rx_backplane_bit_clock_low,
    input wire logic       rx_backplane_bit_clock_high,
    input wire logic       rx_backplane_frame_sync_low,
    input wire logic       rx_backplane_frame_sync_high,
    input wire logic [7:0] framing_bit,
    input wire logic       group_low_serial_out,
    input wire logic       group_high_serial_out
);
    import tbm_pkg::*;

    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic bit_on = mux_enable && interface_mode == MODE_BITMUX;
    wire logic hm_on = mux_enable && interface_mode == MODE_HMVIP;

    // Idle low line while disabled, idle high line in unused mode 3; looked at one cycle
    // after the run, since the last update may land on its final edge
    a_off_quiet:
        assert property ((!mux_enable) [*8] |=> !group_low_serial_out)
        else $error("low output busy while disabled");
    a_bad_mode_quiet:
        assert property ((interface_mode == 2'h3) [*8] |=> !group_high_serial_out)
        else $error("high output busy in unused mode");
    // Output only moves a few clk after a bit clock rise
    a_low_on_rise:
        assert property ($changed(group_low_serial_out) |-> $past(rx_backplane_bit_clock_low, 3)
            && !$past(rx_backplane_bit_clock_low, 6)) else $error("low output moved off rise");
    a_high_holds:
        assert property ($fell(rx_backplane_bit_clock_high) |-> ##2
            $stable(group_high_serial_out) [*4]) else $error("high output moved in low phase");
    // Framing octet then filler, counted from the sync
    a_bit_frame_low:
        assert property (bit_on && $rose(rx_backplane_frame_sync_low) |-> ##10
            group_low_serial_out == framing_bit[0] ##8 group_low_serial_out == framing_bit[0]
            ##8 group_low_serial_out == framing_bit[1] ##48 !group_low_serial_out)
        else $error("low bit mode frame start wrong");
    a_bit_frame_high:
        assert property (bit_on && $rose(rx_backplane_frame_sync_high) |-> ##10
            group_high_serial_out == framing_bit[4] ##16 group_high_serial_out == framing_bit[5])
        else $error("high bit mode frame start wrong");
    a_hm_frame_low:
        assert property (hm_on && $rose(rx_backplane_frame_sync_low) |-> ##27
            group_low_serial_out == framing_bit[0] ##16 group_low_serial_out == framing_bit[1]
            ##48 !group_low_serial_out) else $error("low byte mode frame start wrong");
    a_hm_frame_high:
        assert property (hm_on && $rose(rx_backplane_frame_sync_high) |-> ##35
            group_high_serial_out == framing_bit[4] ##8 group_high_serial_out == framing_bit[5])
        else $error("high byte mode frame start wrong");
endmodule // tbm_rx_mux_chk

bind tbm_rx_mux tbm_rx_mux_chk chk
(
    .clk                          (clk),
    .rst_n                        (rst_n),
    .mux_enable                   (mux_enable),
    .interface_mode               (interface_mode),
    .rx_backplane_bit_clock_low   (rx_backplane_bit_clock_low),
    .rx_backplane_bit_clock_high  (rx_backplane_bit_clock_high),
    .rx_backplane_frame_sync_low  (rx_backplane_frame_sync_low),
    .rx_backplane_frame_sync_high (rx_backplane_frame_sync_high),
    .framing_bit                  (framing_bit),
    .group_low_serial_out         (group_low_serial_out),
    .group_high_serial_out        (group_high_serial_out)
);

//--- dv/tbm_rx_mux_bench.sv
// Purpose : Self checking bench of the backplane multiplexer
// Assumes : Two terminal models, one per group, on unrelated phases
// Notes   : Whole frames are compared after the store is filled
`timescale 1ns/10ps
module tbm_rx_mux_bench;
    import tbm_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, mux_enable = 1'b1, wr_en = 1'b0;
    logic [1:0] interface_mode = MODE_BITMUX;
    // Framing nibbles are not palindromes, so a reversed channel order shows
    logic [7:0] framing_bit = 8'h2d, wr_payload = 8'h00, pay [8][24];
    logic [3:0] wr_signaling = 4'h0, sig [8][24];
    logic [2:0] wr_channel = 3'h0;
    logic [4:0] wr_slot = 5'h0;
    logic       rx_backplane_bit_clock_low, rx_backplane_bit_clock_high;
    logic       rx_backplane_frame_sync_low, rx_backplane_frame_sync_high;
    logic       group_low_serial_out, group_high_serial_out;
    int         fail_count = 0, n_compared = 0, cyc = 0;
    wire logic  hm = interface_mode == MODE_HMVIP;

    always #12.5 clk = ~clk;
    tbm_rx_mux dut
    (
        .clk                          (clk),
        .rst_n                        (rst_n),
        .mux_enable                   (mux_enable),
        .interface_mode               (interface_mode),
        .rx_backplane_bit_clock_low   (rx_backplane_bit_clock_low),
        .rx_backplane_bit_clock_high  (rx_backplane_bit_clock_high),
        .rx_backplane_frame_sync_low  (rx_backplane_frame_sync_low),
        .rx_backplane_frame_sync_high (rx_backplane_frame_sync_high),
        .framing_bit                  (framing_bit),
        .wr_en                        (wr_en),
        .wr_channel                   (wr_channel),
        .wr_slot                      (wr_slot),
        .wr_payload                   (wr_payload),
        .wr_signaling                 (wr_signaling),
        .group_low_serial_out         (group_low_serial_out),
        .group_high_serial_out        (group_high_serial_out)
    );
    // Different phase and frame offset per group exposes any coupling
    tbm_term_model #(.PHASE(7.0), .START(11'h7f8)) lo_m (.hmvip(hm),
        .serial_in(group_low_serial_out), .bit_clock(rx_backplane_bit_clock_low),
        .frame_sync(rx_backplane_frame_sync_low));
    tbm_term_model #(.PHASE(61.0), .START(11'h5dc)) hi_m (.hmvip(hm),
        .serial_in(group_high_serial_out), .bit_clock(rx_backplane_bit_clock_high),
        .frame_sync(rx_backplane_frame_sync_high));

    // ----------
    // Helpers
    // ----------
    task automatic check(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Expected bit at position p of group g, byte interleaved when m
    function automatic logic exp_bit(int g, int p, logic m);
        int off, ts, ii, ch, b;
        off = p % 256;
        ts = (p / 256) * 3 + (off - 64) / 64;
        ii = (off - 64) % 64;
        ch = g * 4 + (m ? ii / 16 : (ii / 2) % 4);
        b = m ? (ii / 2) % 8 : ii / 8;
        if (off < 64)
            return (p < 8) ? framing_bit[g * 4 + p / 2] : 1'b0;
        return (ii % 2 == 1 && b >= 4) ? sig[ch][ts][7 - b] : pay[ch][ts][7 - b];
    endfunction

    task automatic fill_store();
        for (int c = 0; c < 8; c++)
            for (int s = 0; s < 24; s++)
            begin
                pay[c][s] = 8'(c * 29 + s * 7 + 53);
                sig[c][s] = 4'(c + s * 5);
                {wr_en, wr_channel, wr_slot} = {1'b1, 3'(c), 5'(s)};
                {wr_payload, wr_signaling} = {pay[c][s], sig[c][s]};
                @(negedge clk);
            end
        wr_en = 1'b0;
    endtask

    // Mode changes land well away from either group's frame edge
    task automatic set_mode(input logic en, input logic [1:0] m);
        wait (lo_m.pos[8:0] == 9'h100);
        @(negedge clk);
        {mux_enable, interface_mode} = {en, m};
    endtask

    task automatic check_frames();
        int f0, f1;
        {f0, f1} = {lo_m.frames, hi_m.frames};
        wait (lo_m.frames >= f0 + 2 && hi_m.frames >= f1 + 2);
        for (int p = 0; p < 2048; p++)
        begin
            check(lo_m.cap[p], exp_bit(0, p, hm));
            check(hi_m.cap[p], exp_bit(1, p, hm));
        end
    endtask

    // ----------
    // Scenarios
    // ----------
    task automatic run_bitmux();
        set_mode(1'b1, MODE_BITMUX);
        check_frames();
        $display("bit multiplexed frames done");
    endtask

    task automatic run_hmvip();
        set_mode(1'b1, MODE_HMVIP);
        check_frames();
        $display("byte interleaved frames done");
    endtask

    task automatic run_off();
        // Disabled, then enabled with each of the two unused mode codes
        for (int k = 0; k < 3; k++)
        begin
            set_mode(k != 0, (k == 0) ? MODE_HMVIP : ((k == 1) ? 2'h3 : 2'h0));
            repeat (35) @(negedge rx_backplane_bit_clock_low);
            check(group_low_serial_out, 1'b0);
            check(group_high_serial_out, 1'b0);
        end
        $display("idle modes done");
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Run needs about 9500 bit times (76000 clk); ceiling leaves some margin
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        fill_store();
        run_bitmux();
        run_hmvip();
        run_off();
        give_verdict();
    end
endmodule // tbm_rx_mux_bench
